// ==== usbirq_pkg.sv ====
// Package for the USB interrupt status and line termination block.
// Assumes a single 50 MHz system clock and a plain register port.
package usbirq_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [23:0] USBIRQ_OFS_TERM    = 24'h1C001C;
  localparam logic [23:0] USBIRQ_OFS_STAT    = 24'h1C0080;
  localparam logic [23:0] USBIRQ_OFS_ENABLE  = 24'h1C0084;
  localparam logic [23:0] USBIRQ_OFS_MODE    = 24'h1C0094;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int USBIRQ_TERM_PULLUP   = 7;
  localparam int USBIRQ_TERM_DP_PD    = 5;
  localparam int USBIRQ_TERM_DM_PD    = 4;
  localparam int USBIRQ_TERM_ROLE     = 2;
  localparam logic [7:0] USBIRQ_TERM_MASK = 8'hB4;

  localparam int USBIRQ_ST_STALL  = 7;
  localparam int USBIRQ_ST_ATTACH = 6;
  localparam int USBIRQ_ST_RESUME = 5;
  localparam int USBIRQ_ST_SLEEP  = 4;
  localparam int USBIRQ_ST_TOKEN  = 3;
  localparam int USBIRQ_ST_FRAME  = 2;
  localparam int USBIRQ_ST_ERROR  = 1;
  localparam int USBIRQ_ST_BUSRST = 0;

  localparam int USBIRQ_MODE_MODULE_EN = 0;
  localparam int USBIRQ_MODE_HOST      = 1;
  localparam logic [7:0] USBIRQ_MODE_MASK = 8'h03;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] USBIRQ_STAT_RST   = 8'h00;
  localparam logic [7:0] USBIRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] USBIRQ_TERM_RST   = 8'h00;
  localparam logic [7:0] USBIRQ_MODE_RST   = 8'h00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int USBIRQ_CLK_HZ        = 50_000_000;
  localparam int USBIRQ_IDLE_MS       = 3;
  localparam int USBIRQ_IDLE_CYC      = USBIRQ_CLK_HZ / 1000 * USBIRQ_IDLE_MS;
  localparam int USBIRQ_BUSRST_NS_X10 = 25_000;
  localparam int USBIRQ_BUSRST_CYC    =
    (USBIRQ_BUSRST_NS_X10 / 10 * (USBIRQ_CLK_HZ / 1_000_000) + 999) / 1000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } usbirq_bus_t;

  typedef struct packed {
    logic stall;
    logic attach;
    logic resume;
    logic bus_active;
    logic token_done;
    logic frame_start_event;
    logic error;
    logic bus_reset;
  } usbirq_evt_t;

  typedef struct packed {
    logic dplus_pullup_en;
    logic dplus_pulldown_en;
    logic dminus_pulldown_en;
  } usbirq_term_t;

endpackage : usbirq_pkg

// ==== usbirq_top.sv ====
// USB main interrupt status, enable and data line termination control.
// Assumes events come from serial engine logic on sys_clk_i, except
// bus_reset and bus_active which are line conditions and are synchronised.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module usbirq_top
  import usbirq_pkg::*;
#(
  parameter int IDLE_CYCLES = USBIRQ_IDLE_CYC
)(
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  // Register port
  input  wire usbirq_pkg::usbirq_bus_t bus_i,
  output var  logic [7:0]              rdata_o,
  // Engine events, same clock except bus_reset and bus_active
  input  wire usbirq_pkg::usbirq_evt_t evt_i,
  input  wire logic                    dual_role_status_i,
  // Transfer status advance request
  output var  logic                    token_ack_o,
  // Termination and interrupt
  output var  usbirq_pkg::usbirq_term_t term_o,
  output var  logic                    irq_o
);
  import usbirq_pkg::*;

  initial
  begin
    if (IDLE_CYCLES < 2)
      $error("IDLE_CYCLES too small");
  end

  // ------------------------------------------------------------
  // Line condition synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic [1:0] act_sync_r;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rst_sync_r <= 2'h0;
      act_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], evt_i.bus_reset};
      act_sync_r <= {act_sync_r[0], evt_i.bus_active};
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic       wr_term;
  logic       wr_stat;
  logic       wr_en;
  logic       wr_mode;
  logic [7:0] clr_mask;
  assign wr_term  = bus_i.wr && (bus_i.addr == USBIRQ_OFS_TERM);
  assign wr_stat  = bus_i.wr && (bus_i.addr == USBIRQ_OFS_STAT);
  assign wr_en    = bus_i.wr && (bus_i.addr == USBIRQ_OFS_ENABLE);
  assign wr_mode  = bus_i.wr && (bus_i.addr == USBIRQ_OFS_MODE);
  assign clr_mask = wr_stat ? bus_i.wdata : 8'h00;

  logic [7:0] term_r;
  logic [7:0] enable_r;
  logic [7:0] mode_r;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      term_r   <= USBIRQ_TERM_RST;
      enable_r <= USBIRQ_ENABLE_RST;
      mode_r   <= USBIRQ_MODE_RST;
    end
    else
    begin
      if (wr_term)
        term_r <= bus_i.wdata & USBIRQ_TERM_MASK;
      if (wr_en)
        enable_r <= bus_i.wdata;
      if (wr_mode)
        mode_r <= bus_i.wdata & USBIRQ_MODE_MASK;
    end
  end

  // ------------------------------------------------------------
  // Idle timer and bus reset qualification
  // ------------------------------------------------------------
  // Activity restarts the count; the sleep event fires once per idle spell.
  logic [31:0] idle_cnt_r;
  logic        idle_hit;
  assign idle_hit = !act_sync_r[1] && (idle_cnt_r == 32'(IDLE_CYCLES - 1));
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      idle_cnt_r <= 32'h0;
    else if (act_sync_r[1])
      idle_cnt_r <= 32'h0;
    else if (idle_cnt_r < 32'(IDLE_CYCLES))
      idle_cnt_r <= idle_cnt_r + 32'h1;
  end

  logic [15:0] rst_cnt_r;
  logic        rst_hit;
  assign rst_hit = rst_sync_r[1] && (rst_cnt_r == 16'(USBIRQ_BUSRST_CYC - 1));
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rst_cnt_r <= 16'h0;
    else if (!rst_sync_r[1])
      rst_cnt_r <= 16'h0;
    else if (rst_cnt_r < 16'(USBIRQ_BUSRST_CYC))
      rst_cnt_r <= rst_cnt_r + 16'h1;
  end

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  logic [7:0] set_vec;
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[USBIRQ_ST_STALL]  = evt_i.stall;
    set_vec[USBIRQ_ST_ATTACH] = evt_i.attach && mode_r[USBIRQ_MODE_HOST];
    set_vec[USBIRQ_ST_RESUME] = evt_i.resume;
    set_vec[USBIRQ_ST_SLEEP]  = idle_hit;
    set_vec[USBIRQ_ST_TOKEN]  = evt_i.token_done;
    set_vec[USBIRQ_ST_FRAME]  = evt_i.frame_start_event;
    set_vec[USBIRQ_ST_ERROR]  = evt_i.error;
    set_vec[USBIRQ_ST_BUSRST] = rst_hit;
  end

  logic [7:0] stat_r;
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      stat_r <= USBIRQ_STAT_RST;
    else
      stat_r <= (stat_r & ~clr_mask) | set_vec;
  end

  // Pulse to the transfer status logic on a one written to the token bit
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      token_ack_o <= 1'b0;
    else
      token_ack_o <= clr_mask[USBIRQ_ST_TOKEN];
  end

  // ------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= (|(((stat_r & ~clr_mask) | set_vec) & enable_r))
               || dual_role_status_i;
  end

  // ------------------------------------------------------------
  // Termination
  // ------------------------------------------------------------
  // Role mode overrides the direct bits so software cannot mix both.
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      term_o <= '0;
    else if (term_r[USBIRQ_TERM_ROLE])
    begin
      term_o.dplus_pullup_en    <= mode_r[USBIRQ_MODE_MODULE_EN]
                                   && !mode_r[USBIRQ_MODE_HOST];
      term_o.dplus_pulldown_en  <= mode_r[USBIRQ_MODE_HOST];
      term_o.dminus_pulldown_en <= mode_r[USBIRQ_MODE_HOST];
    end
    else
    begin
      term_o.dplus_pullup_en    <= term_r[USBIRQ_TERM_PULLUP];
      term_o.dplus_pulldown_en  <= term_r[USBIRQ_TERM_DP_PD];
      term_o.dminus_pulldown_en <= term_r[USBIRQ_TERM_DM_PD];
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
    begin
      case (bus_i.addr)
        USBIRQ_OFS_TERM:   rdata_o <= term_r;
        USBIRQ_OFS_STAT:   rdata_o <= stat_r;
        USBIRQ_OFS_ENABLE: rdata_o <= enable_r;
        USBIRQ_OFS_MODE:   rdata_o <= mode_r;
        default:           rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

endmodule : usbirq_top

`default_nettype wire

// ==== usbirq_chk.sv ====
// Checker for the USB interrupt and termination block.
// Sees only the top ports; shadows enable, mode and termination writes.
`timescale 1ns/1ps
`default_nettype none
module usbirq_chk
  import usbirq_pkg::*;
#(
  parameter int IDLE_CYCLES = 20
)(
  // Clock, reset, register port
  input wire logic                     sys_clk_i,
  input wire logic                     reset_i,
  input wire usbirq_pkg::usbirq_bus_t  bus_i,
  input wire logic [7:0]               rdata_o,
  // Events and outputs
  input wire usbirq_pkg::usbirq_evt_t  evt_i,
  input wire logic                     dual_role_status_i,
  input wire logic                     token_ack_o,
  input wire usbirq_pkg::usbirq_term_t term_o,
  input wire logic                     irq_o
);
  logic [7:0]   en_r;
  logic [7:0]   t_r;
  logic [7:0]   md_r;
  logic         wen;
  logic         wst;
  usbirq_term_t texp;
  assign wen  = bus_i.wr && bus_i.addr == USBIRQ_OFS_ENABLE;
  assign wst  = bus_i.wr && bus_i.addr == USBIRQ_OFS_STAT;
  assign texp = t_r[2] ? {md_r[0] & ~md_r[1], md_r[1], md_r[1]} : {t_r[7], t_r[5], t_r[4]};
  always_ff @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
    begin
      en_r <= 8'h00;
      t_r  <= 8'h00;
      md_r <= 8'h00;
    end
    else if (bus_i.wr)
    begin
      if (wen) en_r <= bus_i.wdata;
      if (bus_i.addr == USBIRQ_OFS_TERM) t_r <= bus_i.wdata & USBIRQ_TERM_MASK;
      if (bus_i.addr == USBIRQ_OFS_MODE) md_r <= bus_i.wdata & 8'h03;
    end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_clr3;
    wst && bus_i.wdata[3];
  endsequence
  property p_term; term_o == $past(texp); endproperty
  a_term: assert property (p_term) else $error("termination wrong");
  property p_term_rd; bus_i.rd && bus_i.addr == USBIRQ_OFS_TERM |=> rdata_o == $past(t_r); endproperty
  a_term_rd: assert property (p_term_rd) else $error("term readback");
  property p_en_rd; bus_i.rd && bus_i.addr == USBIRQ_OFS_ENABLE |=> rdata_o == $past(en_r); endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback");
  property p_ack; s_clr3 |=> token_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no token ack");
  property p_ack_cause; token_ack_o |-> $past(wst && bus_i.wdata[3]); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray token ack");
  property p_evt_irq; |(evt_i & en_r & 8'hAE) |=> irq_o; endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("event without irq");
  property p_dual; dual_role_status_i |=> irq_o; endproperty
  a_dual: assert property (p_dual) else $error("dual role not ORed");
  property p_noirq; en_r == 8'h00 && !wen && !dual_role_status_i |=> !irq_o; endproperty
  a_noirq: assert property (p_noirq) else $error("irq while disabled");
  property p_stay; irq_o && !$past(dual_role_status_i) && !wst && !wen |=> irq_o; endproperty
  a_stay: assert property (p_stay) else $error("irq dropped");
endmodule : usbirq_chk
bind usbirq_top usbirq_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_usbirq_chk (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o), .evt_i(evt_i),
  .dual_role_status_i(dual_role_status_i), .token_ack_o(token_ack_o), .term_o(term_o),
  .irq_o(irq_o));
`default_nettype wire

// ==== usbirq_far_end.sv ====
// Far-side bus model: engine event pulses and line conditions.
// Called by the bench; changes only just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module usbirq_far_end
  import usbirq_pkg::*;
(
  // Clock and events
  input  wire logic                    sys_clk_i,
  output var  usbirq_pkg::usbirq_evt_t evt_o
);
  // Bus starts active so the idle timer is quiet
  initial evt_o = 8'h10;
  task automatic pulse(input int b);
    @(posedge sys_clk_i);
    evt_o[b] <= 1'b1;
    @(posedge sys_clk_i);
    evt_o[b] <= 1'b0;
  endtask : pulse
  task automatic hold(input int b, input logic v, input int n);
    @(posedge sys_clk_i);
    evt_o[b] <= v;
    repeat (n) @(posedge sys_clk_i);
  endtask : hold
endmodule : usbirq_far_end
`default_nettype wire

// ==== tb_top.sv ====
// Bench for the USB interrupt and termination block.
// Register tasks plus far-side model; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import usbirq_pkg::*;
  localparam logic [23:0] ST = USBIRQ_OFS_STAT;
  localparam logic [23:0] EN = USBIRQ_OFS_ENABLE;
  localparam logic [23:0] TM = USBIRQ_OFS_TERM;
  localparam logic [23:0] MD = USBIRQ_OFS_MODE;
  logic         sys_clk_i = 1'b0;
  logic         reset_i   = 1'b1;
  logic         dual      = 1'b0;
  usbirq_bus_t  b         = '0;
  usbirq_evt_t  evt;
  usbirq_term_t term;
  logic [7:0]   rdata;
  logic         irq;
  logic         tack;
  int           n_errors = 0, check_count = 0, cyc = 0;
  int           ev[6] = '{7, 6, 5, 3, 2, 1};
  always #10 sys_clk_i = ~sys_clk_i;
  usbirq_top #(.IDLE_CYCLES(20)) u_usbirq_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .bus_i(b), .rdata_o(rdata), .evt_i(evt), .dual_role_status_i(dual),
    .token_ack_o(tack), .term_o(term), .irq_o(irq));
  usbirq_far_end u_usbirq_far_end (.sys_clk_i(sys_clk_i), .evt_o(evt));
  task automatic results;
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    b <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    b.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    b <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    b.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd
  // Outputs are registered, so let two edges land before looking
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : settle
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(ST, 8'h00);
    rd(EN, 8'h00);
    wr(TM, 8'hFF);
    rd(TM, 8'hB4);
    wr(MD, 8'h01);
    settle();
    chk("term", 8'h04, {5'h00, term});
    wr(MD, 8'h03);
    settle();
    chk("term", 8'h03, {5'h00, term});
    wr(TM, 8'h80);
    settle();
    chk("term", 8'h04, {5'h00, term});
    wr(TM, 8'h30);
    settle();
    chk("term", 8'h03, {5'h00, term});
    wr(EN, 8'hFF);
    foreach (ev[i])
    begin
      u_usbirq_far_end.pulse(ev[i]);
      rd(ST, 8'h01 << ev[i]);
      chk("irq", 8'h01, {7'h00, irq});
      wr(ST, ~(8'h01 << ev[i]));
      rd(ST, 8'h01 << ev[i]);
      wr(ST, 8'h01 << ev[i]);
      rd(ST, 8'h00);
    end
    // Token done: read status first, then a one to bit 3 must pulse the ack
    u_usbirq_far_end.pulse(3);
    rd(ST, 8'h08);
    wr(ST, 8'h08);
    #1 chk("token_ack", 8'h01, {7'h00, tack});
    wr(EN, 8'h00);
    u_usbirq_far_end.pulse(7);
    settle();
    chk("irq", 8'h00, {7'h00, irq});
    wr(EN, 8'h80);
    settle();
    chk("irq", 8'h01, {7'h00, irq});
    wr(ST, 8'h80);
    dual <= 1'b1;
    settle();
    chk("irq", 8'h01, {7'h00, irq});
    dual <= 1'b0;
    u_usbirq_far_end.hold(4, 1'b0, 12);
    rd(ST, 8'h00);
    u_usbirq_far_end.hold(4, 1'b1, 3);
    u_usbirq_far_end.hold(4, 1'b0, 12);
    rd(ST, 8'h00);
    u_usbirq_far_end.hold(4, 1'b0, 20);
    rd(ST, 8'h10);
    u_usbirq_far_end.hold(4, 1'b1, 1);
    wr(ST, 8'h10);
    u_usbirq_far_end.hold(0, 1'b1, 100);
    rd(ST, 8'h00);
    u_usbirq_far_end.hold(0, 1'b1, 40);
    rd(ST, 8'h01);
    wr(ST, 8'h01);
    u_usbirq_far_end.hold(0, 1'b1, 200);
    rd(ST, 8'h00);
    u_usbirq_far_end.hold(0, 1'b0, 10);
    u_usbirq_far_end.hold(0, 1'b1, 140);
    rd(ST, 8'h01);
    wr(24'h1C0000, 8'hFF);
    rd(24'h1C0000, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
